// ==== design/msd_pkg.sv ====
// package of constants for the memory space decoder
package msd_pkg;
    localparam logic [15:0] MSD_CODE_8K_LAST  = 16'h1FFF;
    localparam logic [15:0] MSD_CODE_16K_LAST = 16'h3FFF;
    localparam logic [7:0]  MSD_UPPER_BASE    = 8'h80;
    localparam logic [7:0]  MSD_RD_RESET      = 8'h00;
    localparam logic [7:0]  MSD_UNIMPL_VALUE  = 8'hFF;
    // code memory variants
    typedef enum logic [1:0] {
        MSD_CODE_NONE = 2'h0,
        MSD_CODE_8K   = 2'h1,
        MSD_CODE_16K  = 2'h3
    } msd_variant_t;
endpackage

// ==== design/msd_memory_space_decode.sv ====
// address-space decoder with lower/upper data ram and register-space storage
`timescale 1ns/1ns
`default_nettype none
// Operation
// [R01] program and data memory are separate spaces, each up to 64 Kbytes
// [R02] external-access select low sends every fetch to external memory
// [R03] 8K variant, select high: 0000H-1FFFH internal, 2000H upward external
// [R04] 16K variant, select high: 0000H-3FFFH internal, 4000H-FFFFH external
// [R05] data 00H-7FH reached alike by direct and indirect access
// [R06] indirect 80H-FFH reaches upper data ram, never register space
// [R07] direct 80H-FFH reaches register space, never upper data ram
// [R08] upper ram and register space are separate storage
// [R09] unimplemented register writes store nothing, reads give unspecified value
// [R10] variant without code memory fetches everything externally
module msd_memory_space_decode
    import msd_pkg::*;
#(
    parameter msd_variant_t VARIANT  = MSD_CODE_8K,
    parameter logic [127:0] REG_IMPL = {128{1'b1}}
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        external_access_select_n,
    input  wire logic        fetch_req,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        data_req,
    input  wire logic        data_we,
    input  wire logic        data_indirect,
    input  wire logic [7:0]  data_addr,
    input  wire logic [7:0]  data_wdata,
    output logic             fetch_internal_r,
    output logic             fetch_external_r,
    output logic [15:0]      fetch_addr_r,
    output logic             data_rvalid_r,
    output logic [7:0]       data_rdata_r
);
    // ----------------------------------------
    // pin synchroniser
    // ----------------------------------------
    logic [2:0] ea_sync_r;
    logic       ea_n_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ea_sync_r <= 3'h0;
            ea_n_r    <= 1'b0;
        end else begin
            ea_sync_r <= {ea_sync_r[1:0], external_access_select_n};
            if (ea_sync_r[1] == ea_sync_r[2]) begin
                ea_n_r <= ea_sync_r[2]; // R02
            end
        end
    end

    // a level not yet held by two stages leaves the old select in force
    a_sync_hold: assert property ( // R02
        @(posedge clk) disable iff (!arst_n)
        (ea_sync_r[1] != ea_sync_r[2]) |=> $stable(ea_n_r)
    ) else $error("select changed before two stages agreed");
    a_sync_take: assert property ( // R02
        @(posedge clk) disable iff (!arst_n)
        (ea_sync_r[1] == ea_sync_r[2]) |=> (ea_n_r == $past(ea_sync_r[2]))
    ) else $error("select did not follow agreed stages");

    // ----------------------------------------
    // program fetch routing
    // ----------------------------------------
    // 16-bit fetch address spans the whole 64 Kbyte code space
    logic fetch_int_nxt;
    always_comb begin
        fetch_int_nxt = 1'b0;
        case (VARIANT)
            MSD_CODE_8K:  fetch_int_nxt = ea_n_r && (fetch_addr <= MSD_CODE_8K_LAST);  // R03
            MSD_CODE_16K: fetch_int_nxt = ea_n_r && (fetch_addr <= MSD_CODE_16K_LAST); // R04
            default:      fetch_int_nxt = 1'b0; // R10
        endcase
        if (!ea_n_r) begin
            fetch_int_nxt = 1'b0; // R02
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_internal_r <= 1'b0;
            fetch_external_r <= 1'b0;
            fetch_addr_r     <= 16'h0000;
        end else begin
            fetch_internal_r <= fetch_req && fetch_int_nxt;
            fetch_external_r <= fetch_req && !fetch_int_nxt; // R01
            if (fetch_req) begin
                fetch_addr_r <= fetch_addr;
            end
        end
    end

    a_ea_low_external: assert property ( // R02
        @(posedge clk) disable iff (!arst_n)
        (fetch_req && !ea_n_r) |=> (fetch_external_r && !fetch_internal_r)
    ) else $error("fetch internal while select low");
    a_no_code_external: assert property ( // R10
        @(posedge clk) disable iff (!arst_n)
        (fetch_req && VARIANT == MSD_CODE_NONE) |=> (fetch_external_r && !fetch_internal_r)
    ) else $error("romless fetch internal");
    a_8k_split: assert property ( // R03
        @(posedge clk) disable iff (!arst_n)
        (fetch_req && ea_n_r && VARIANT == MSD_CODE_8K)
        |=> (fetch_internal_r == (fetch_addr_r <= MSD_CODE_8K_LAST))
    ) else $error("8k split wrong");
    a_16k_split: assert property ( // R04
        @(posedge clk) disable iff (!arst_n)
        (fetch_req && ea_n_r && VARIANT == MSD_CODE_16K)
        |=> (fetch_internal_r == (fetch_addr_r <= MSD_CODE_16K_LAST))
    ) else $error("16k split wrong");
    a_fetch_onehot: assert property ( // R01
        @(posedge clk) disable iff (!arst_n)
        !(fetch_internal_r && fetch_external_r)
    ) else $error("fetch routed twice");
    a_fetch_answer: assert property ( // R01
        @(posedge clk) disable iff (!arst_n)
        fetch_req |=> (fetch_internal_r || fetch_external_r)
    ) else $error("fetch routed nowhere");
    a_fetch_idle: assert property ( // R01
        @(posedge clk) disable iff (!arst_n)
        !fetch_req |=> (!fetch_internal_r && !fetch_external_r)
    ) else $error("fetch pulse without request");
    a_fetch_capture: assert property ( // R01
        @(posedge clk) disable iff (!arst_n)
        fetch_req |=> (fetch_addr_r == $past(fetch_addr))
    ) else $error("fetch address not captured");

    // ----------------------------------------
    // internal data storage
    // ----------------------------------------
    // three separate arrays; upper ram and register space never alias
    logic [7:0] lower_mem_r [128];
    logic [7:0] upper_mem_r [128]; // R08
    logic [7:0] reg_mem_r   [128]; // R08
    logic       is_upper;
    logic [6:0] idx;
    assign is_upper = (data_addr >= MSD_UPPER_BASE);
    assign idx      = data_addr[6:0];

    generate
        for (genvar i = 0; i < 128; i++) begin : g_cell
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    lower_mem_r[i] <= MSD_RD_RESET;
                    upper_mem_r[i] <= MSD_RD_RESET;
                    reg_mem_r[i]   <= MSD_RD_RESET;
                end else if (data_req && data_we && idx == 7'(i)) begin
                    if (!is_upper) begin
                        lower_mem_r[i] <= data_wdata; // R05
                    end else if (data_indirect) begin
                        upper_mem_r[i] <= data_wdata; // R06
                    end else if (REG_IMPL[i]) begin
                        reg_mem_r[i] <= data_wdata; // R07 R09
                    end
                end
            end
        end
    endgenerate

    a_upper_indirect: assert property ( // R06
        @(posedge clk) disable iff (!arst_n)
        (data_req && data_we && data_addr[7] && data_indirect)
        |=> (reg_mem_r[$past(idx)] == $past(reg_mem_r[idx]))
    ) else $error("indirect write hit register space");
    a_reg_direct: assert property ( // R07 R08
        @(posedge clk) disable iff (!arst_n)
        (data_req && data_we && data_addr[7] && !data_indirect)
        |=> (upper_mem_r[$past(idx)] == $past(upper_mem_r[idx]))
    ) else $error("direct write hit upper ram");
    a_unimpl_write: assert property ( // R09
        @(posedge clk) disable iff (!arst_n)
        (data_req && data_we && data_addr[7] && !data_indirect && !REG_IMPL[idx])
        |=> (reg_mem_r[$past(idx)] == $past(reg_mem_r[idx]))
    ) else $error("unimplemented register slot stored a write");

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_rvalid_r <= 1'b0;
            data_rdata_r  <= MSD_RD_RESET;
        end else begin
            data_rvalid_r <= data_req && !data_we;
            if (data_req && !data_we) begin
                if (!is_upper) begin
                    data_rdata_r <= lower_mem_r[idx]; // R05
                end else if (data_indirect) begin
                    data_rdata_r <= upper_mem_r[idx]; // R06
                end else if (REG_IMPL[idx]) begin
                    data_rdata_r <= reg_mem_r[idx]; // R07
                end else begin
                    data_rdata_r <= MSD_UNIMPL_VALUE; // R09
                end
            end
        end
    end

    a_read_valid: assert property ( // R05
        @(posedge clk) disable iff (!arst_n)
        (data_req && !data_we) |=> data_rvalid_r
    ) else $error("read answered late");
    a_read_quiet: assert property ( // R05
        @(posedge clk) disable iff (!arst_n)
        !(data_req && !data_we) |=> !data_rvalid_r
    ) else $error("read valid without read");
    a_lower_same: assert property ( // R05
        @(posedge clk) disable iff (!arst_n)
        (data_req && data_we && !data_addr[7]) ##1
        (data_req && !data_we && data_addr == $past(data_addr) &&
         data_indirect != $past(data_indirect))
        |=> (data_rdata_r == $past(data_wdata, 2))
    ) else $error("lower ram modes disagree");
    a_upper_read: assert property ( // R06
        @(posedge clk) disable iff (!arst_n)
        (data_req && !data_we && data_addr[7] && data_indirect)
        |=> (data_rdata_r == $past(upper_mem_r[idx]))
    ) else $error("indirect read missed upper ram");
    a_reg_read: assert property ( // R07
        @(posedge clk) disable iff (!arst_n)
        (data_req && !data_we && data_addr[7] && !data_indirect && REG_IMPL[idx])
        |=> (data_rdata_r == $past(reg_mem_r[idx]))
    ) else $error("direct read missed register space");
    a_unimpl_read: assert property ( // R09
        @(posedge clk) disable iff (!arst_n)
        (data_req && !data_we && data_addr[7] && !data_indirect && !REG_IMPL[idx])
        |=> (data_rdata_r == MSD_UNIMPL_VALUE)
    ) else $error("unimplemented read wrong");
endmodule
`default_nettype wire

// ==== tb/msd_ext_mem.sv ====
// behavioural external program memory standing past the decoder
`timescale 1ns/1ns
`default_nettype none
module msd_ext_mem (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ext_fetch,
    input  wire logic [15:0] ext_addr,
    output logic      [15:0] last_addr,
    output logic      [7:0]  n_ext
);
    // counts fetches and keeps the last address; no data returns since the decoder has no fetch data port
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            n_ext <= 8'h00;
            last_addr <= 16'h0000;
        end else if (ext_fetch) begin
            n_ext <= n_ext + 8'h01;
            last_addr <= ext_addr;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_memory_space_decode.sv ====
// testbench for the memory space decoder
`timescale 1ns/1ns
`default_nettype none
module tb_memory_space_decode;
    import msd_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, ea_n = 1'b1, f_req = 1'b0;
    logic d_req = 1'b0, d_we = 1'b0, d_ind = 1'b0;
    logic [15:0] f_addr = 16'h0000;
    logic [7:0] d_addr = 8'h00, d_wd = 8'h00, n_ext;
    logic fi, fe, rv, fi16, fe16, fi0, fe0;
    logic [7:0] rd;
    logic [15:0] fa, last_a;
    int n_fail = 0, n_compared = 0;
    // -------------------------------
    // design and far side
    // -------------------------------
    msd_memory_space_decode #(
        .VARIANT  (MSD_CODE_8K),
        .REG_IMPL (~128'h10)
    ) i_msd_memory_space_decode (
        .clk(clk), .arst_n(arst_n), .external_access_select_n(ea_n), .fetch_req(f_req),
        .fetch_addr(f_addr), .data_req(d_req), .data_we(d_we), .data_indirect(d_ind),
        .data_addr(d_addr), .data_wdata(d_wd), .fetch_internal_r(fi), .fetch_external_r(fe),
        .fetch_addr_r(fa), .data_rvalid_r(rv), .data_rdata_r(rd));
    // the other two code variants see the same stimulus; only their routing is judged
    msd_memory_space_decode #(
        .VARIANT (MSD_CODE_16K)
    ) i_msd_memory_space_decode_16k (
        .clk(clk), .arst_n(arst_n), .external_access_select_n(ea_n), .fetch_req(f_req),
        .fetch_addr(f_addr), .data_req(d_req), .data_we(d_we), .data_indirect(d_ind),
        .data_addr(d_addr), .data_wdata(d_wd), .fetch_internal_r(fi16),
        .fetch_external_r(fe16), .fetch_addr_r(), .data_rvalid_r(), .data_rdata_r());
    msd_memory_space_decode #(
        .VARIANT (MSD_CODE_NONE)
    ) i_msd_memory_space_decode_none (
        .clk(clk), .arst_n(arst_n), .external_access_select_n(ea_n), .fetch_req(f_req),
        .fetch_addr(f_addr), .data_req(d_req), .data_we(d_we), .data_indirect(d_ind),
        .data_addr(d_addr), .data_wdata(d_wd), .fetch_internal_r(fi0),
        .fetch_external_r(fe0), .fetch_addr_r(), .data_rvalid_r(), .data_rdata_r());
    msd_ext_mem i_msd_ext_mem (.clk(clk), .arst_n(arst_n), .ext_fetch(fe), .ext_addr(fa),
        .last_addr(last_a), .n_ext(n_ext));
    initial begin
        forever #10 clk = ~clk;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task fetch(input logic [15:0] a, input logic i8, input logic i16);
        @(posedge clk) #2 f_req = 1'b1;
        f_addr = a;
        @(posedge clk) #2 f_req = 1'b0;
        chk({10'h000, fi, fe, fi16, fe16, fi0, fe0},
            {10'h000, i8, ~i8, i16, ~i16, 2'b01});
        chk(fa, a);
    endtask
    task acc(input logic we, input logic ind, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk) #2 d_req = 1'b1;
        d_we = we;
        d_ind = ind;
        d_addr = a;
        d_wd = v;
        @(posedge clk) #2 d_req = 1'b0;
        if (!we) begin
            chk({7'h00, rv, rd}, {8'h01, v});
        end else begin
            chk({15'h0000, rv}, 16'h0000);
        end
    endtask
    // -------------------------------
    // scenarios
    // -------------------------------
    task t_code_8k;
        fetch(16'h0000, 1'b1, 1'b1);
        fetch(16'h1FFF, 1'b1, 1'b1);
        fetch(16'h2000, 1'b0, 1'b1);
        fetch(16'h3FFF, 1'b0, 1'b1);
        fetch(16'h4000, 1'b0, 1'b0);
        fetch(16'hFFFF, 1'b0, 1'b0);
    endtask
    task t_pin_low;
        ea_n = 1'b0;
        repeat (6) @(posedge clk);
        fetch(16'h0000, 1'b0, 1'b0);
        fetch(16'h1FFF, 1'b0, 1'b0);
        // the far side counts the last pulse one edge later
        @(posedge clk) #2;
        chk({8'h00, n_ext}, 16'h0006);
        chk(last_a, 16'h1FFF);
    endtask
    task t_lower;
        acc(1'b1, 1'b0, 8'h7F, 8'h3C);
        acc(1'b0, 1'b1, 8'h7F, 8'h3C);
        acc(1'b1, 1'b1, 8'h00, 8'hC3);
        acc(1'b0, 1'b0, 8'h00, 8'hC3);
        // back to back: the read in the next cycle sees the new byte
        @(posedge clk) #2 d_req = 1'b1;
        d_we = 1'b1;
        d_ind = 1'b0;
        d_addr = 8'h10;
        d_wd = 8'h5A;
        @(posedge clk) #2 d_we = 1'b0;
        d_ind = 1'b1;
        @(posedge clk) #2 d_req = 1'b0;
        chk({7'h00, rv, rd}, {8'h01, 8'h5A});
    endtask
    task t_split;
        acc(1'b1, 1'b1, 8'hA0, 8'h55);
        acc(1'b1, 1'b0, 8'hA0, 8'hAA);
        acc(1'b0, 1'b1, 8'hA0, 8'h55);
        acc(1'b0, 1'b0, 8'hA0, 8'hAA);
        acc(1'b0, 1'b1, 8'hFF, 8'h00);
    endtask
    task t_unimpl;
        acc(1'b1, 1'b0, 8'h84, 8'h12);
        acc(1'b0, 1'b0, 8'h84, MSD_UNIMPL_VALUE);
        acc(1'b0, 1'b1, 8'h84, 8'h00);
    endtask
    task conclude;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #2 arst_n = 1'b1;
        repeat (6) @(posedge clk);
        t_code_8k();
        t_lower();
        t_split();
        t_unimpl();
        t_pin_low();
        conclude();
    end
    initial begin
        #20000;
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
